//--- include/fpsr_pkg.sv
package fpsr_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] GUARD_OFS = 8'h40;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h80;
   localparam logic [3:0] GUARD_LANES = 4'h3;

   // ------------------------------------------------------------
   // Valid area guard fields
   // ------------------------------------------------------------
   localparam logic [15:0] GUARD_RESET = 16'h0001;
   localparam int GUARD_KEY_HI = 15;
   localparam int GUARD_KEY_LO = 8;
   localparam int GUARD_PROT_POS = 0;
   localparam logic [7:0] GUARD_KEY_UNLOCK = 8'hFE;
   localparam logic [0:0] GUARD_PROT_RESET = 1'h1;

   // ------------------------------------------------------------
   // Sequencer status fields
   // ------------------------------------------------------------
   localparam logic [31:0] STATUS_RESET = 32'h00008000;
   localparam int STATUS_READY_POS = 15;
   localparam int STATUS_ERC_UNC_POS = 29;
   localparam int STATUS_ERC_COR_POS = 28;
   // Always-zero positions: 31..30, 19, 7, 1..0
   localparam logic [31:0] STATUS_RSVD_MASK = 32'hC0080083;
   // Configuration, switch and security ECC flags
   localparam logic [31:0] STATUS_INST0_ONLY_MASK = 32'h0F000030;
   // Erase counter ECC flags and bit 17/16 flags
   localparam logic [31:0] STATUS_CODE_FLASH_MASK = 32'h30030000;
   localparam logic [31:0] STATUS_OWNED_MASK = 32'h30008000;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic sel;
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } fpsr_bus_req_s;

   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
   } fpsr_bus_rsp_s;

   typedef struct packed {
      logic setup_init;
      logic cmd_first_write;
      logic cmd_done;
      logic erc_uncorr_evt;
      logic erc_corr_evt;
      logic clear_start;
   } fpsr_seq_evt_s;

   typedef struct packed {
      logic double_map;
      logic prog_erase_cmd;
      logic target_valid_area;
   } fpsr_cmd_chk_s;

   typedef struct packed {
      logic flag;
   } fpsr_flag_state_s;

   typedef struct packed {
      logic guard_prot;
      logic ready;
      logic cmd_blocked;
      fpsr_bus_rsp_s rsp;
   } fpsr_state_s;

endpackage : fpsr_pkg

//--- hw/fpsr_sticky_flag.sv
`timescale 1ns/10ps
`default_nettype none

module fpsr_sticky_flag (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic set_evt,
   input wire logic clear_evt,
   output logic flag_q
);

   fpsr_pkg::fpsr_flag_state_s st_q;
   fpsr_pkg::fpsr_flag_state_s st_d;

   // Set wins over a clear in the same cycle so no event is lost
   always_comb begin
      st_d = st_q;
      if (set_evt) begin
         st_d.flag = 1'h1;
      end else if (clear_evt) begin
         st_d.flag = 1'h0;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= '{flag: 1'h0};
      end else begin
         st_q <= st_d;
      end
   end

   assign flag_q = st_q.flag;

endmodule : fpsr_sticky_flag

`default_nettype wire

//--- hw/fpsr_regs.sv
// Functional notes
// - Setup-init bit resets guard register
// - Guard reads 0x0001 after reset
// - Key field never stored, reads zero
// - Protect bit updates only with key FE
// - Guard writes ignored while sequencer busy
// - Guard bits 7..1 read zero
// - Protect bit shields valid area in double map
// - No code flash: protect bit inert
// - Status read-only, any width, writes ignored
// - Status reads 0x00008000 after reset
// - Non-zero instance: config/switch/security ECC zero
// - No code flash: erase counter, bit17/16 zero
// - Uncorrectable erase counter error sets bit 29, locks
// - Corrected erase counter error sets bit 28, no lock
// - Clear/forced-stop start clears both erase flags
// - Status bits 31..30 read zero
`timescale 1ns/10ps
`default_nettype none

module fpsr_regs #(
   parameter int INSTANCE_ID = 0,
   parameter int NUM_INSTANCES = 3,
   parameter bit HAS_CODE_FLASH = 1'b1
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire fpsr_pkg::fpsr_bus_req_s bus_req,
   output fpsr_pkg::fpsr_bus_rsp_s bus_rsp,
   input wire fpsr_pkg::fpsr_seq_evt_s seq_evt,
   input wire fpsr_pkg::fpsr_cmd_chk_s cmd_chk,
   input wire logic [31:0] seq_status,
   output logic sequencer_ready_flag,
   output logic valid_area_protect_bit,
   output logic cmd_blocked,
   output logic erase_count_uncorrectable_flag,
   output logic erase_count_corrected_flag,
   output logic cmd_lock_req
);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (INSTANCE_ID < 0 || INSTANCE_ID >= NUM_INSTANCES) begin : g_bad_instance
      $error("fpsr_regs: INSTANCE_ID out of range");
   end

   localparam logic [31:0] INST_MASK =
      (INSTANCE_ID != 0) ? fpsr_pkg::STATUS_INST0_ONLY_MASK : 32'h00000000;
   localparam logic [31:0] CF_MASK =
      HAS_CODE_FLASH ? 32'h00000000 : fpsr_pkg::STATUS_CODE_FLASH_MASK;
   localparam logic [31:0] READ_ZERO_MASK = fpsr_pkg::STATUS_RSVD_MASK | INST_MASK | CF_MASK;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   logic hit_guard;
   logic hit_status;
   logic guard_wr;
   logic guard_key_ok;
   logic erc_unc_q;
   logic erc_cor_q;
   logic erc_clear;
   logic [31:0] status_val;
   fpsr_pkg::fpsr_state_s st_q;
   fpsr_pkg::fpsr_state_s st_d;

   assign hit_guard = bus_req.sel && (bus_req.addr == fpsr_pkg::GUARD_OFS);
   assign hit_status = bus_req.sel && (bus_req.addr == fpsr_pkg::STATUS_OFS);
   // A narrower write cannot carry key and data together, so it is dropped
   assign guard_wr = hit_guard && bus_req.wr &&
                     (bus_req.be[1:0] == fpsr_pkg::GUARD_LANES[1:0]);
   assign guard_key_ok =
      (bus_req.wdata[fpsr_pkg::GUARD_KEY_HI:fpsr_pkg::GUARD_KEY_LO] ==
       fpsr_pkg::GUARD_KEY_UNLOCK);

   // ------------------------------------------------------------
   // Erase counter ECC flags
   // ------------------------------------------------------------
   // Setup init doubles as a soft clear; an event in the same cycle still wins
   assign erc_clear = seq_evt.clear_start || seq_evt.setup_init;

   fpsr_sticky_flag u_erc_unc (
      .core_clk(core_clk),
      .rstn(rstn),
      .set_evt(seq_evt.erc_uncorr_evt && HAS_CODE_FLASH),
      .clear_evt(erc_clear),
      .flag_q(erc_unc_q)
   );

   fpsr_sticky_flag u_erc_cor (
      .core_clk(core_clk),
      .rstn(rstn),
      .set_evt(seq_evt.erc_corr_evt && HAS_CODE_FLASH),
      .clear_evt(erc_clear),
      .flag_q(erc_cor_q)
   );

   // ------------------------------------------------------------
   // Status composition
   // ------------------------------------------------------------
   // Bits owned here replace whatever the sequencer drives on them
   always_comb begin
      status_val = seq_status & ~fpsr_pkg::STATUS_OWNED_MASK;
      status_val[fpsr_pkg::STATUS_READY_POS] = st_q.ready;
      status_val[fpsr_pkg::STATUS_ERC_UNC_POS] = erc_unc_q;
      status_val[fpsr_pkg::STATUS_ERC_COR_POS] = erc_cor_q;
      status_val = status_val & ~READ_ZERO_MASK;
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      st_d.rsp.ack = bus_req.sel;
      st_d.rsp.rdata = 32'h00000000;

      // Busy from first command write until the sequencer reports done
      if (seq_evt.setup_init || seq_evt.cmd_done) begin
         st_d.ready = 1'h1;
      end else if (seq_evt.cmd_first_write) begin
         st_d.ready = 1'h0;
      end

      // Setup init takes priority over a simultaneous write
      if (seq_evt.setup_init) begin
         st_d.guard_prot = fpsr_pkg::GUARD_PROT_RESET;
      end else if (guard_wr && guard_key_ok && st_q.ready) begin
         st_d.guard_prot = bus_req.wdata[fpsr_pkg::GUARD_PROT_POS];
      end

      if (bus_req.sel && !bus_req.wr) begin
         if (hit_guard) begin
            // Key and reserved bits are not held, only the protect bit
            st_d.rsp.rdata = {31'h00000000, st_q.guard_prot};
         end else if (hit_status) begin
            st_d.rsp.rdata = status_val;
         end
      end

      // Only meaningful where a code flash user area exists
      st_d.cmd_blocked = HAS_CODE_FLASH && cmd_chk.double_map &&
                         cmd_chk.prog_erase_cmd && cmd_chk.target_valid_area &&
                         st_d.guard_prot;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= '{guard_prot: fpsr_pkg::GUARD_PROT_RESET,
                   ready: fpsr_pkg::STATUS_RESET[fpsr_pkg::STATUS_READY_POS],
                   cmd_blocked: 1'h0,
                   rsp: '{ack: 1'h0, rdata: 32'h00000000}};
      end else begin
         st_q <= st_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign bus_rsp = st_q.rsp;
   assign sequencer_ready_flag = st_q.ready;
   assign valid_area_protect_bit = st_q.guard_prot;
   assign cmd_blocked = st_q.cmd_blocked;
   assign erase_count_uncorrectable_flag = erc_unc_q;
   assign erase_count_corrected_flag = erc_cor_q;
   // Sticky uncorrectable flag holds the sequencer in command lock
   assign cmd_lock_req = erc_unc_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   // Read strobes seen by the checks below
   logic rd_guard;
   logic rd_status;
   assign rd_guard = hit_guard && !bus_req.wr;
   assign rd_status = hit_status && !bus_req.wr;

   property p_setup_init_guard;
      seq_evt.setup_init |=> valid_area_protect_bit;
   endproperty
   a_setup_init_guard: assert property (p_setup_init_guard)
      else $error("guard bit not restored by setup init");

   property p_guard_read_init;
      seq_evt.setup_init ##1 (rd_guard && !seq_evt.setup_init)
         |=> bus_rsp.ack && bus_rsp.rdata == {16'h0000, fpsr_pkg::GUARD_RESET};
   endproperty
   a_guard_read_init: assert property (p_guard_read_init)
      else $error("guard register not at reset value after init");

   property p_guard_read_zero;
      rd_guard |=> bus_rsp.rdata[31:1] == 31'h00000000
                   && bus_rsp.rdata[0] == $past(valid_area_protect_bit);
   endproperty
   a_guard_read_zero: assert property (p_guard_read_zero)
      else $error("guard key or reserved bits read nonzero");

   property p_bad_key;
      guard_wr && !guard_key_ok && !seq_evt.setup_init |=> $stable(valid_area_protect_bit);
   endproperty
   a_bad_key: assert property (p_bad_key)
      else $error("guard bit changed with wrong key");

   property p_good_key;
      guard_wr && guard_key_ok && sequencer_ready_flag && !seq_evt.setup_init
         |=> valid_area_protect_bit == $past(bus_req.wdata[0]);
   endproperty
   a_good_key: assert property (p_good_key)
      else $error("guard bit not updated with unlock key");

   property p_busy_ignore;
      guard_wr && !sequencer_ready_flag && !seq_evt.setup_init
         |=> $stable(valid_area_protect_bit);
   endproperty
   a_busy_ignore: assert property (p_busy_ignore)
      else $error("guard bit changed while sequencer busy");

   property p_busy_window;
      seq_evt.cmd_first_write && !seq_evt.cmd_done && !seq_evt.setup_init
         |=> !sequencer_ready_flag;
   endproperty
   a_busy_window: assert property (p_busy_window)
      else $error("ready flag not cleared by first command write");

   property p_shield;
      cmd_chk.double_map && cmd_chk.prog_erase_cmd && cmd_chk.target_valid_area
         && HAS_CODE_FLASH ##1 $stable(valid_area_protect_bit)
         |-> cmd_blocked == valid_area_protect_bit;
   endproperty
   a_shield: assert property (p_shield)
      else $error("valid area shield does not follow protect bit");

   property p_no_shield;
      !cmd_chk.double_map || !HAS_CODE_FLASH |=> !cmd_blocked;
   endproperty
   a_no_shield: assert property (p_no_shield)
      else $error("command blocked outside double map or without code flash");

   property p_status_ro;
      hit_status && bus_req.wr && !seq_evt.setup_init && !seq_evt.cmd_done
         && !seq_evt.cmd_first_write |=> $stable(sequencer_ready_flag);
   endproperty
   a_status_ro: assert property (p_status_ro)
      else $error("status write had an effect");

   property p_status_ready;
      rd_status |=> bus_rsp.rdata[fpsr_pkg::STATUS_READY_POS] == $past(sequencer_ready_flag)
                    && bus_rsp.rdata[31:30] == 2'h0;
   endproperty
   a_status_ready: assert property (p_status_ready)
      else $error("status ready or reserved bits wrong");

   property p_inst_zero;
      rd_status && INSTANCE_ID != 0 |=> (bus_rsp.rdata & fpsr_pkg::STATUS_INST0_ONLY_MASK) == 0;
   endproperty
   a_inst_zero: assert property (p_inst_zero)
      else $error("instance-0-only ECC flags visible");

   property p_cf_zero;
      rd_status && !HAS_CODE_FLASH |=> (bus_rsp.rdata & fpsr_pkg::STATUS_CODE_FLASH_MASK) == 0;
   endproperty
   a_cf_zero: assert property (p_cf_zero)
      else $error("code flash flags visible without code flash");

   property p_unc_lock;
      seq_evt.erc_uncorr_evt && HAS_CODE_FLASH
         |=> erase_count_uncorrectable_flag && cmd_lock_req;
   endproperty
   a_unc_lock: assert property (p_unc_lock)
      else $error("uncorrectable erase counter error not flagged");

   property p_unc_visible;
      rd_status && HAS_CODE_FLASH
         |=> bus_rsp.rdata[fpsr_pkg::STATUS_ERC_UNC_POS] == $past(erase_count_uncorrectable_flag);
   endproperty
   a_unc_visible: assert property (p_unc_visible)
      else $error("status bit 29 does not show the uncorrectable flag");

   property p_cor_visible;
      rd_status && HAS_CODE_FLASH
         |=> bus_rsp.rdata[fpsr_pkg::STATUS_ERC_COR_POS] == $past(erase_count_corrected_flag);
   endproperty
   a_cor_visible: assert property (p_cor_visible)
      else $error("status bit 28 does not show the corrected flag");

   // Command lock with ready high must not freeze the guard register
   property p_lock_write;
      guard_wr && guard_key_ok && sequencer_ready_flag && cmd_lock_req && !seq_evt.setup_init
         |=> valid_area_protect_bit == $past(bus_req.wdata[0]);
   endproperty
   a_lock_write: assert property (p_lock_write)
      else $error("guard write refused in command lock with ready set");

   property p_cor_nolock;
      seq_evt.erc_corr_evt && HAS_CODE_FLASH && !erase_count_uncorrectable_flag
         && !seq_evt.erc_uncorr_evt |=> erase_count_corrected_flag && !cmd_lock_req;
   endproperty
   a_cor_nolock: assert property (p_cor_nolock)
      else $error("corrected erase counter error mishandled");

   property p_clear;
      erc_clear && !seq_evt.erc_uncorr_evt && !seq_evt.erc_corr_evt
         |=> !erase_count_uncorrectable_flag && !erase_count_corrected_flag;
   endproperty
   a_clear: assert property (p_clear)
      else $error("erase counter flags not cleared");

   property p_ready_return;
      seq_evt.cmd_done |=> sequencer_ready_flag;
   endproperty
   a_ready_return: assert property (p_ready_return)
      else $error("ready flag not restored when the sequencer finishes");

   property p_ack;
      bus_req.sel |=> bus_rsp.ack;
   endproperty
   a_ack: assert property (p_ack)
      else $error("register access not acknowledged");

   property p_write_no_data;
      bus_req.sel && bus_req.wr |=> bus_rsp.rdata == 32'h00000000;
   endproperty
   a_write_no_data: assert property (p_write_no_data)
      else $error("write returned read data");

   property p_nocf_flags;
      !HAS_CODE_FLASH |-> !erase_count_uncorrectable_flag && !erase_count_corrected_flag;
   endproperty
   a_nocf_flags: assert property (p_nocf_flags)
      else $error("erase counter flag set without code flash");

   // ------------------------------------------------------------
   // Cover points
   // ------------------------------------------------------------
   c_key_write: cover property (guard_wr && guard_key_ok && sequencer_ready_flag);
   c_busy_write: cover property (guard_wr && guard_key_ok && !sequencer_ready_flag);
   c_unc_then_clear: cover property (seq_evt.erc_uncorr_evt ##[1:20] seq_evt.clear_start);
   c_blocked: cover property (cmd_blocked);
   c_init_read: cover property (seq_evt.setup_init ##1 rd_guard);

endmodule : fpsr_regs

`default_nettype wire

//--- verif/fpsr_tb.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
   $display("CHECK FAILED t=%0t %s", $time, m); end end

module testbench;

   // ------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------
   localparam logic [5:0] EV_INIT = 6'b100000;
   localparam logic [5:0] EV_FIRST = 6'b010000;
   localparam logic [5:0] EV_DONE = 6'b001000;
   localparam logic [5:0] EV_UNC = 6'b000100;
   localparam logic [5:0] EV_COR = 6'b000010;
   localparam logic [5:0] EV_CLR = 6'b000001;

   logic core_clk;
   logic rstn;
   fpsr_pkg::fpsr_bus_req_s bus_req;
   fpsr_pkg::fpsr_bus_rsp_s rsp0;
   fpsr_pkg::fpsr_bus_rsp_s rsp1;
   fpsr_pkg::fpsr_seq_evt_s seq_evt;
   fpsr_pkg::fpsr_cmd_chk_s cmd_chk;
   logic [31:0] seq_status;
   logic rdy0, prot0, blk0, unc0, cor0, lck0, blk1, unc1;
   logic [31:0] rd0;
   logic [31:0] rd1;
   int err_count;
   int cmp_count;

   fpsr_regs fpsr_regs_inst (
      .core_clk(core_clk), .rstn(rstn), .bus_req(bus_req), .bus_rsp(rsp0),
      .seq_evt(seq_evt), .cmd_chk(cmd_chk), .seq_status(seq_status),
      .sequencer_ready_flag(rdy0), .valid_area_protect_bit(prot0), .cmd_blocked(blk0),
      .erase_count_uncorrectable_flag(unc0), .erase_count_corrected_flag(cor0),
      .cmd_lock_req(lck0)
   );

   // Second instance: not instance 0 and without code flash
   fpsr_regs #(.INSTANCE_ID(1), .NUM_INSTANCES(3), .HAS_CODE_FLASH(1'b0)) fpsr_regs_nocf_inst (
      .core_clk(core_clk), .rstn(rstn), .bus_req(bus_req), .bus_rsp(rsp1),
      .seq_evt(seq_evt), .cmd_chk(cmd_chk), .seq_status(seq_status),
      .sequencer_ready_flag(), .valid_area_protect_bit(), .cmd_blocked(blk1),
      .erase_count_uncorrectable_flag(unc1), .erase_count_corrected_flag(),
      .cmd_lock_req()
   );

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] d);
      @(posedge core_clk);
      bus_req <= '{sel: 1'b1, wr: w, addr: a, be: be, wdata: d};
      @(posedge core_clk);
      bus_req <= '0;
      #1;
      `CHK(rsp0.ack, 1'b1, "no ack")
      rd0 = rsp0.rdata;
      rd1 = rsp1.rdata;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      xfer(1'b1, a, be, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [3:0] be);
      xfer(1'b0, a, be, 32'h00000000);
   endtask : rd

   task automatic ev(input logic [5:0] e);
      @(posedge core_clk);
      seq_evt <= e;
      @(posedge core_clk);
      seq_evt <= '0;
      #1;
   endtask : ev

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results

   initial begin
      #(40 * 5000);
      err_count++;
      results();
   end

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      err_count = 0;
      cmp_count = 0;
      rstn = 1'b0;
      bus_req = '0;
      seq_evt = '0;
      cmd_chk = '0;
      seq_status = 32'h00000000;
      repeat (10) @(posedge core_clk);
      rstn <= 1'b1;
      rd(8'h40, 4'h3);
      `CHK(rd0, 32'h00000001, "guard reset value")
      rd(8'h80, 4'hF);
      `CHK(rd0, 32'h00008000, "status reset value")
      `CHK(rdy0, 1'b1, "ready after reset")
      rd(8'h44, 4'hF);
      `CHK(rd0, 32'h00000000, "unmapped read")
      // Wrong keys keep the bit; key and value always in one 16-bit write
      wr(8'h40, 4'h3, 32'h0000FD00);
      `CHK(prot0, 1'b1, "wrong key accepted")
      wr(8'h40, 4'h3, 32'h0000FF00);
      `CHK(prot0, 1'b1, "wrong key accepted")
      wr(8'h40, 4'h3, 32'h0000FE00);
      `CHK(prot0, 1'b0, "key FE refused")
      rd(8'h40, 4'h3);
      `CHK(rd0, 32'h00000000, "key field read back")
      wr(8'h40, 4'h3, 32'h0000FE01);
      rd(8'h40, 4'h3);
      `CHK(rd0, 32'h00000001, "reserved guard bits")
      // Busy sequencer ignores guard writes
      ev(EV_FIRST);
      `CHK(rdy0, 1'b0, "ready not dropped")
      wr(8'h40, 4'h3, 32'h0000FE00);
      `CHK(prot0, 1'b1, "write while busy")
      ev(EV_DONE);
      `CHK(rdy0, 1'b1, "ready not back")
      wr(8'h40, 4'h3, 32'h0000FE00);
      `CHK(prot0, 1'b0, "write after done")
      // Soft reset by setup-init
      // Read issued the cycle after setup init lands must see the reset value
      fork
         ev(EV_INIT);
         begin
            @(posedge core_clk);
            rd(8'h40, 4'h3);
         end
      join
      `CHK(prot0, 1'b1, "setup init")
      `CHK(rd0, 32'h00000001, "guard after setup init")
      // Shielding of the valid area
      @(posedge core_clk);
      cmd_chk <= '{double_map: 1'b1, prog_erase_cmd: 1'b1, target_valid_area: 1'b1};
      repeat (2) @(posedge core_clk);
      #1;
      `CHK(blk0, 1'b1, "not shielded")
      `CHK(blk1, 1'b0, "shield without code flash")
      wr(8'h40, 4'h3, 32'h0000FE00);
      @(posedge core_clk);
      #1;
      `CHK(blk0, 1'b0, "shield while unprotected")
      wr(8'h40, 4'h3, 32'h0000FE01);
      @(posedge core_clk);
      cmd_chk.double_map <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      `CHK(blk0, 1'b0, "shield outside double map")
      // Erase counter ECC flags
      ev(EV_UNC);
      `CHK(unc0, 1'b1, "uncorrectable flag")
      `CHK(lck0, 1'b1, "no command lock")
      `CHK(unc1, 1'b0, "flag without code flash")
      rd(8'h80, 4'hF);
      `CHK(rd0, 32'h20008000, "status bit 29")
      `CHK(rd1, 32'h00008000, "status bit 29 on second")
      wr(8'h40, 4'h3, 32'h0000FE00);
      `CHK(prot0, 1'b0, "write in command lock")
      ev(EV_CLR);
      `CHK(unc0, 1'b0, "clear uncorrectable")
      `CHK(lck0, 1'b0, "lock after clear")
      ev(EV_COR);
      `CHK(cor0, 1'b1, "corrected flag")
      `CHK(lck0, 1'b0, "lock on corrected")
      rd(8'h80, 4'h1);
      `CHK(rd0, 32'h10008000, "status bit 28 byte read")
      wr(8'h80, 4'hF, 32'hFFFFFFFF);
      rd(8'h80, 4'h3);
      `CHK(rd0, 32'h10008000, "status written")
      ev(EV_CLR);
      `CHK(cor0, 1'b0, "clear corrected")
      // Masking of sequencer status per instance
      @(posedge core_clk);
      seq_status <= 32'hFFFFFFFF;
      rd(8'h80, 4'hF);
      `CHK(rd0, ~(fpsr_pkg::STATUS_RSVD_MASK | fpsr_pkg::STATUS_OWNED_MASK) | 32'h00008000,
           "status masking inst 0")
      `CHK(rd1, ~(fpsr_pkg::STATUS_RSVD_MASK | fpsr_pkg::STATUS_OWNED_MASK |
                  fpsr_pkg::STATUS_INST0_ONLY_MASK | fpsr_pkg::STATUS_CODE_FLASH_MASK) |
                32'h00008000, "status masking second")
      `CHK(rd1[31:30], 2'b00, "bits 31..30")
      results();
   end

endmodule : testbench

`undef CHK
`default_nettype wire
